// *** rtl/engage_pkg.sv ***
package engage_pkg;

  // System states, Gray coded along engage path 0-1-3 and 4-5
  typedef enum logic [2:0] {
    ST_ALL_OFF   = 3'h0,
    ST_DISP_ON   = 3'h1,
    ST_YAW_ON    = 3'h2,
    ST_DISP_YAW  = 3'h3,
    ST_AP_ON     = 3'h6,
    ST_AP_WHEEL  = 3'h7
  } sys_state_e;

  // Pilot switch inputs
  typedef struct packed {
    logic disp_button;
    logic mode_button;
    logic go_around;
    logic wheel_steering_override;
    logic yaw_switch;
    logic ap_switch;
    logic dump;
    logic manual_trim;
  } switches_s;

  // Monitor flags
  typedef struct packed {
    logic gyro_valid;
    logic self_test_ok;
    logic trim_monitor_ok;
  } monitors_s;

  // Annunciator and servo outputs
  typedef struct packed {
    logic bars_biased;
    logic disp_light;
    logic yaw_light;
    logic yaw_enable;
    logic ap_light;
    logic ap_enable;
    logic servo_engage;
    logic wheel_alters_disp;
    logic yaw_solenoid;
    logic ap_solenoid;
  } lights_s;

  // Timing
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned FADE_TIME_MS = 2500;
  localparam int unsigned FADE_CYCLES = (CLK_HZ / 1000) * FADE_TIME_MS;
  localparam int unsigned FLASH_COUNT = 4;
  localparam int unsigned FLASH_HALF_MS = 250;
  localparam int unsigned FLASH_HALF_CYCLES = (CLK_HZ / 1000) * FLASH_HALF_MS;
  localparam int unsigned RAMP_WIDTH = 16;

endpackage

// *** rtl/alert_flasher.sv ***
`timescale 1ns/1ps
`default_nettype none
module alert_flasher
  import engage_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = FLASH_HALF_CYCLES,
  parameter int unsigned FLASHES = FLASH_COUNT
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Trigger
  input wire logic i_start,
  // Outputs
  output logic o_flash,
  output logic o_horn
);
  logic [31:0] tick_reg, tick_next;
  logic [3:0] phase_reg, phase_next;
  logic flash_reg, flash_next;
  logic horn_reg, horn_next;

  // Two phases per flash; restart on a new trigger
  always_comb begin
    tick_next = tick_reg;
    phase_next = phase_reg;
    flash_next = flash_reg;
    horn_next = horn_reg;
    if (i_start) begin
      tick_next = '0;
      phase_next = '0;
      flash_next = 1'b1;
      horn_next = 1'b1;
    end else if (horn_reg) begin
      if (tick_reg == 32'(HALF_CYCLES - 1)) begin
        tick_next = '0;
        if (phase_reg == 4'(2 * FLASHES - 1)) begin
          horn_next = 1'b0;
          flash_next = 1'b0;
        end else begin
          phase_next = phase_reg + 4'h1;
          flash_next = ~flash_reg;
        end
      end else begin
        tick_next = tick_reg + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_reg <= '0;
      phase_reg <= '0;
      flash_reg <= 1'b0;
      horn_reg <= 1'b0;
    end else begin
      tick_reg <= tick_next;
      phase_reg <= phase_next;
      flash_reg <= flash_next;
      horn_reg <= horn_next;
    end
  end

  assign o_flash = flash_reg;
  assign o_horn = horn_reg;
endmodule
`default_nettype wire

// *** rtl/engage_state_machine.sv ***
//
// Contract
// RL1 - Six states encode display, yaw, autopilot; state 5 adds wheel override
// RL2 - Qualified events move per table; don't-care keeps the state
// RL3 - Display button toggles 0/1 and 2/3; ignored in 4 and 5
// RL4 - Mode or go-around takes 0 to 1, 2 to 3; go-around 3,4,5 to 3
// RL5 - Wheel override on takes 0 to 1, 4 to 5; keeps 1 and 3
// RL6 - Wheel override release takes 5 to 4 with a fade ramp
// RL7 - Yaw engaged with flag takes 0 to 2 and 1 to 3
// RL8 - Yaw dropped takes 2 to 0, 3 to 1, 4/5 to 1
// RL9 - Autopilot engaged with flag only from 3, to 4 with fade ramp
// RL10 - Outside linkage turns yaw switch on with the autopilot switch
// RL11 - Autopilot dropped takes 4 and 5 to 3, alert from 5
// RL12 - Involuntary exit from 4 or 5 flashes light four times, sounds horn
// RL13 - Enables act through solenoids released by listed faults
// RL14 - Requests with unmet conditions are ignored
// RL15 - States 0,2 bias bars away; states 1,3 light display
// RL16 - States 2-5 light and enable yaw; 4,5 light and enable autopilot
// RL17 - Servo engage in state 4, dropped in state 5
// RL18 - Yaw flag is no dump, gyro valid, self-test good
// RL19 - Autopilot flag adds no go-around, trim ok, trim off or override
// RL20 - Display flag is gyro valid and self-test good
// RL21 - Reset starts in state 0 with yaw and autopilot flags true
// RL22 - Display flag false returns any state to 0, alert from 4/5
// RL23 - Buttons are edge detected after a released period
//
`timescale 1ns/1ps
`default_nettype none
module engage_state_machine
  import engage_pkg::*;
#(
  parameter int unsigned FADE_LEN = FADE_CYCLES,
  parameter int unsigned FLASH_HALF = FLASH_HALF_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Pilot switches and monitors
  input wire engage_pkg::switches_s i_sw,
  input wire engage_pkg::monitors_s i_mon,
  // Annunciator and servos
  output engage_pkg::lights_s o_lights,
  output logic o_ap_light_flash,
  output logic o_horn,
  output logic [2:0] o_state,
  output logic [RAMP_WIDTH-1:0] o_fade_gain,
  output logic o_fading
);
  import engage_pkg::*;

  localparam logic [RAMP_WIDTH-1:0] GAIN_FULL = {RAMP_WIDTH{1'b1}};
  // State 0 lamp pattern, so the bars stay biased away straight out of reset
  localparam lights_s LIGHTS_RESET = '{bars_biased: 1'b1, default: 1'b0};

  // Map state to its documented number
  function automatic logic [2:0] state_num(input sys_state_e s);
    case (s)
      ST_ALL_OFF: state_num = 3'h0;
      ST_DISP_ON: state_num = 3'h1;
      ST_YAW_ON: state_num = 3'h2;
      ST_DISP_YAW: state_num = 3'h3;
      ST_AP_ON: state_num = 3'h4;
      ST_AP_WHEEL: state_num = 3'h5;
      default: state_num = 3'h0;
    endcase
  endfunction

  sys_state_e state_reg, state_next;
  switches_s prev_reg, prev_next;
  logic yaw_flag_reg, yaw_flag_next;
  logic ap_flag_reg, ap_flag_next;
  logic [31:0] fade_cnt_reg, fade_cnt_next;
  logic fading_reg, fading_next;
  logic [RAMP_WIDTH-1:0] gain_reg, gain_next;
  lights_s lights_reg, lights_next;
  logic alert_reg, alert_next;
  logic [2:0] num_reg, num_next;

  logic disp_flag;
  logic disp_press, mode_press, ga_press, wheel_on, wheel_off;
  logic yaw_up, yaw_drop, ap_up, ap_drop;
  logic in_ap;

  // Flags from monitors
  always_comb begin
    disp_flag = i_mon.gyro_valid & i_mon.self_test_ok; // RL20
    yaw_flag_next = ~i_sw.dump & i_mon.gyro_valid & i_mon.self_test_ok; // RL18
    ap_flag_next = yaw_flag_next & ~i_sw.go_around & i_mon.trim_monitor_ok
                   & (~i_sw.manual_trim | i_sw.wheel_steering_override); // RL19
  end

  // Edge detection of momentary switches
  always_comb begin
    prev_next = i_sw;
    disp_press = i_sw.disp_button & ~prev_reg.disp_button; // RL23
    mode_press = i_sw.mode_button & ~prev_reg.mode_button; // RL23
    ga_press = i_sw.go_around & ~prev_reg.go_around; // RL23
    wheel_on = i_sw.wheel_steering_override & ~prev_reg.wheel_steering_override;
    wheel_off = ~i_sw.wheel_steering_override & prev_reg.wheel_steering_override;
    yaw_up = i_sw.yaw_switch & yaw_flag_reg;
    yaw_drop = ~i_sw.yaw_switch | ~yaw_flag_reg;
    ap_up = i_sw.ap_switch & ap_flag_reg;
    ap_drop = ~i_sw.ap_switch | ~ap_flag_reg;
  end

  // Transition table; earlier columns win
  always_comb begin
    state_next = state_reg; // RL2 RL14
    alert_next = 1'b0;
    fade_cnt_next = fade_cnt_reg;
    fading_next = fading_reg;
    in_ap = (state_reg == ST_AP_ON) || (state_reg == ST_AP_WHEEL);
    if (!disp_flag) begin
      state_next = ST_ALL_OFF; // RL22
      alert_next = in_ap; // RL12
    end else begin
      case (state_reg)
        ST_ALL_OFF: begin
          if (disp_press || mode_press || ga_press || wheel_on) begin
            state_next = ST_DISP_ON; // RL3 RL4 RL5
          end else if (yaw_up) begin
            state_next = ST_YAW_ON; // RL7
          end
        end
        ST_DISP_ON: begin
          if (disp_press) begin
            state_next = ST_ALL_OFF; // RL3
          end else if (yaw_up) begin
            state_next = ST_DISP_YAW; // RL7
          end
        end
        ST_YAW_ON: begin
          if (disp_press || mode_press || ga_press) begin
            state_next = ST_DISP_YAW; // RL3 RL4
          end else if (yaw_drop) begin
            state_next = ST_ALL_OFF; // RL8
          end
        end
        ST_DISP_YAW: begin
          if (disp_press) begin
            state_next = ST_YAW_ON; // RL3
          end else if (yaw_drop) begin
            state_next = ST_DISP_ON; // RL8
          end else if (ap_up && !ga_press) begin
            state_next = ST_AP_ON; // RL9
            fading_next = 1'b1;
            fade_cnt_next = '0;
          end
        end
        ST_AP_ON, ST_AP_WHEEL: begin
          if (ga_press) begin
            state_next = ST_DISP_YAW; // RL4
            alert_next = 1'b1; // RL12
          end else if (yaw_drop) begin
            state_next = ST_DISP_ON; // RL8
            alert_next = 1'b1; // RL12
          end else if (ap_drop) begin
            state_next = ST_DISP_YAW; // RL11
            alert_next = (state_reg == ST_AP_WHEEL); // RL11
          end else if (state_reg == ST_AP_ON && wheel_on) begin
            state_next = ST_AP_WHEEL; // RL5
          end else if (state_reg == ST_AP_WHEEL && wheel_off) begin
            state_next = ST_AP_ON; // RL6
            fading_next = 1'b1;
            fade_cnt_next = '0;
          end
        end
        default: state_next = ST_ALL_OFF;
      endcase
    end
    // Ramp runs only while the servos are engaged
    if (state_next != ST_AP_ON) begin
      fading_next = 1'b0;
    end else if (fading_reg && state_reg == ST_AP_ON) begin
      if (fade_cnt_reg == 32'(FADE_LEN - 1)) begin
        fading_next = 1'b0;
      end else begin
        fade_cnt_next = fade_cnt_reg + 32'h0000_0001;
      end
    end
    gain_next = (state_next != ST_AP_ON) ? '0
              : (fading_next ? RAMP_WIDTH'((64'(fade_cnt_next) * GAIN_FULL) / FADE_LEN)
                             : GAIN_FULL);
  end

  // Output decode from next state
  always_comb begin
    num_next = state_num(state_next); // RL1
    lights_next = '0;
    lights_next.bars_biased = (num_next == 3'h0) || (num_next == 3'h2); // RL15
    lights_next.disp_light = (num_next != 3'h0) && (num_next != 3'h2); // RL15
    lights_next.yaw_light = (num_next >= 3'h2); // RL16
    lights_next.yaw_enable = (num_next >= 3'h2); // RL16
    lights_next.ap_light = (num_next >= 3'h4); // RL16
    lights_next.ap_enable = (num_next >= 3'h4); // RL16
    lights_next.servo_engage = (num_next == 3'h4); // RL17
    lights_next.wheel_alters_disp = i_sw.wheel_steering_override
                                    && (num_next == 3'h1 || num_next == 3'h3); // RL5
    lights_next.yaw_solenoid = yaw_flag_next && (num_next >= 3'h2); // RL13
    lights_next.ap_solenoid = ap_flag_next && (num_next >= 3'h4); // RL13
  end

  // State registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ST_ALL_OFF; // RL21
      prev_reg <= '1;
      yaw_flag_reg <= 1'b1; // RL21
      ap_flag_reg <= 1'b1; // RL21
      fade_cnt_reg <= '0;
      fading_reg <= 1'b0;
      gain_reg <= '0;
      lights_reg <= LIGHTS_RESET; // RL15
      alert_reg <= 1'b0;
      num_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      prev_reg <= prev_next;
      yaw_flag_reg <= yaw_flag_next;
      ap_flag_reg <= ap_flag_next;
      fade_cnt_reg <= fade_cnt_next;
      fading_reg <= fading_next;
      gain_reg <= gain_next;
      lights_reg <= lights_next;
      alert_reg <= alert_next;
      num_reg <= num_next;
    end
  end

  // Autopilot light flash and horn
  alert_flasher #(
    .HALF_CYCLES(FLASH_HALF),
    .FLASHES(FLASH_COUNT)
  ) u_flasher (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_start(alert_reg), // RL12
    .o_flash(o_ap_light_flash),
    .o_horn(o_horn)
  );

  assign o_lights = lights_reg;
  assign o_state = num_reg;
  assign o_fade_gain = gain_reg;
  assign o_fading = fading_reg;
endmodule
`default_nettype wire

// *** verification/engage_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module engage_chk
  import engage_pkg::*;
#(
  parameter int unsigned FADE_LEN = 20,
  parameter int unsigned FLASH_HALF = 3
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Watched ports
  input wire engage_pkg::switches_s i_sw,
  input wire engage_pkg::monitors_s i_mon,
  input wire engage_pkg::lights_s o_lights,
  input wire logic o_ap_light_flash,
  input wire logic o_horn,
  input wire logic [2:0] o_state,
  input wire logic [RAMP_WIDTH-1:0] o_fade_gain,
  input wire logic o_fading
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Output lights follow the state number
  state_range_a: assert property (o_state <= 3'h5)
    else $error("state number out of range");
  bars_map_a: assert property (o_lights.bars_biased == (o_state == 0 || o_state == 2))
    else $error("bars bias does not match state");
  yaw_map_a: assert property (o_lights.yaw_enable == (o_state >= 2))
    else $error("yaw enable does not match state");
  ap_map_a: assert property (o_lights.ap_enable == (o_state >= 4))
    else $error("autopilot enable does not match state");
  servo_map_a: assert property (o_lights.servo_engage == (o_state == 4))
    else $error("servo engage does not match state");
  // Transitions and their side effects
  disp_drop_a: assert property (!(i_mon.gyro_valid && i_mon.self_test_ok) |=> o_state == 0)
    else $error("display flag loss did not reach state 0");
  fade_start_a: assert property ((o_state == 4 && $past(o_state) == 3) |-> o_fading)
    else $error("fade ramp not started on engage");
  alert_start_a: assert property (($past(o_state) >= 4 && o_state <= 1) |=> o_horn)
    else $error("no alert on involuntary exit");
  horn_hold_a: assert property ($rose(o_horn) |-> o_horn [*8])
    else $error("horn dropped too early");

  // Main scenarios reached
  cover property (o_state == 5);
  cover property ($rose(o_horn));
  cover property ($rose(o_fading));
endmodule

bind engage_state_machine engage_chk #(.FADE_LEN(FADE_LEN), .FLASH_HALF(FLASH_HALF)) i_engage_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sw(i_sw), .i_mon(i_mon), .o_lights(o_lights),
  .o_ap_light_flash(o_ap_light_flash), .o_horn(o_horn), .o_state(o_state),
  .o_fade_gain(o_fade_gain), .o_fading(o_fading));
`default_nettype wire

// *** verification/pilot_panel.sv ***
`timescale 1ns/1ps
`default_nettype none
module pilot_panel
  import engage_pkg::*;
(
  // Commanded switch positions
  input wire engage_pkg::switches_s i_cmd,
  // Switch levels seen by the controller
  output var engage_pkg::switches_s o_sw
);
  // Autopilot paddle carries the yaw paddle with it
  always_comb begin
    o_sw = i_cmd;
    o_sw.yaw_switch = i_cmd.yaw_switch | i_cmd.ap_switch;
  end
endmodule
`default_nettype wire

// *** verification/tb_engage_state_machine.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_engage_state_machine;
  import engage_pkg::*;
  localparam int unsigned FL = 20;
  logic i_clk = 0;
  logic i_rst_n = 0;
  switches_s cmd = '0;
  switches_s sw;
  monitors_s mon = '1;
  lights_s lt;
  logic fl, hn, fd;
  logic [2:0] st;
  logic [2:0] cur = 0;
  logic [2:0] seen = 0;
  logic [15:0] gn;
  logic [2:0] q[$];
  int err_count = 0;
  int num_checks = 0;
  int seed = 32'hfb93;
  int k;

  // Clock
  always #2.5 i_clk = ~i_clk;

  pilot_panel i_pilot_panel (.i_cmd(cmd), .o_sw(sw));
  engage_state_machine #(.FADE_LEN(FL), .FLASH_HALF(3)) i_engage_state_machine (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sw(sw), .i_mon(mon), .o_lights(lt),
    .o_ap_light_flash(fl), .o_horn(hn), .o_state(st), .o_fade_gain(gn), .o_fading(fd));

  // Compare one value
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Apply switches for one cycle, buttons then released, levels kept
  task automatic act(logic [7:0] v, logic [2:0] e);
    @(posedge i_clk);
    cmd <= v;
    @(posedge i_clk);
    cmd <= v & 8'h1f;
    if (e != cur) q.push_back(e);
    cur = e;
    repeat (3) @(posedge i_clk);
    #1 chk("state", st, e);
    $display("step done state %0d", e);
  endtask

  // Let a running alert finish
  task automatic quiet;
    for (k = 0; k < 60 && hn; k++) @(posedge i_clk);
    chk("horn off", hn, 0);
  endtask

  // Every state change must match the oldest note
  always @(negedge i_clk) begin
    if (st !== seen) begin
      if (q.size() > 0) chk("state change", st, q.pop_front());
      else chk("state held", st, seen);
      seen = st;
    end
  end

  // Hang guard
  initial begin
    #100us;
    err_count++;
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1;
    #1 chk("reset state", st, 0);
    k = $random(seed) & 3;
    repeat (k + 1) act(8'h80, cur ^ 3'h1);
    if (cur != 0) act(8'h80, 0);
    act(8'h04, 2);
    act(8'h08, 2);
    act(8'h48, 3);
    act(8'h0c, 4);
    chk("fading", fd, 1);
    chk("servo", lt.servo_engage, 1);
    repeat (FL + 2) @(posedge i_clk);
    chk("gain", gn, 16'hffff);
    act(8'h1c, 5);
    chk("servo", lt.servo_engage, 0);
    act(8'h0c, 4);
    chk("fading", fd, 1);
    act(8'h8c, 4);
    act(8'h28, 3);
    chk("horn", hn, 1);
    chk("flash", fl, 1);
    quiet();
    act(8'h0c, 4);
    act(8'h00, 1);
    chk("horn", hn, 1);
    quiet();
    act(8'h08, 3);
    act(8'h0c, 4);
    act(8'h1c, 5);
    act(8'h08, 3);
    chk("horn", hn, 1);
    quiet();
    act(8'h0c, 4);
    act(8'h08, 3);
    chk("horn", hn, 0);
    act(8'h09, 3);
    act(8'h0d, 3);
    act(8'h0a, 1);
    @(posedge i_clk);
    q.push_back(3'h0);
    cur = 0;
    mon.gyro_valid <= 0;
    act(8'h00, 0);
    mon.gyro_valid <= 1;
    repeat (4) @(posedge i_clk);
    chk("pending notes", q.size(), 0);
    end_of_test();
  end
endmodule
`default_nettype wire
